// ==== flash_sector_select_status.sv ====
// Memory block selects, sector protection and program/erase sequencing with ready/busy
//
// Overview of operation
// - Decode array drives all memory selects
// - Sixteen 64K primary sectors, own selects
// - Four secondary sectors 16/8/8/32K, own selects
// - One select for whole SRAM block
// - Each sector select ORs three terms
// - Space qualifier remaps sectors between spaces
// - Protected sector rejects program and erase
// - Erase per sector, program per word
// - Erase suspend, read elsewhere, then resume
// - Ready/busy pin drive is configurable
// - Ready/busy low while program or erase
// - Ready/busy high when nothing in progress
// - Read-only protect bit per sector
// - Selects active high during command cycle
`timescale 1ns/1ps
`default_nettype none
`include "flash_sel_defs.svh"

module flash_sector_select_status
    import flash_sel_pkg::*;
#(
    parameter logic [`CNT_W-1:0] PROG_CYCLES = `PROG_CYCLES_DEF,
    parameter logic [`CNT_W-1:0] ERASE_CYCLES = `ERASE_CYCLES_DEF
)
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire bus_t bus_in,
    input wire sel_cfg_t [`N_PRIMARY-1:0] primary_cfg_in,
    input wire sel_cfg_t [`N_SECONDARY-1:0] secondary_cfg_in,
    input wire sel_cfg_t sram_cfg_in,
    input wire logic [`N_PRIMARY-1:0] primary_prot_cfg_in,
    input wire logic [`N_SECONDARY-1:0] secondary_prot_cfg_in,
    input wire logic ready_busy_en_in,
    input wire cmd_req_t cmd_in,
    output logic [`N_PRIMARY-1:0] primary_sector_sel_out,
    output logic [`N_SECONDARY-1:0] secondary_sector_sel_out,
    output logic sram_block_sel_out,
    output logic [`N_PRIMARY-1:0] primary_prot_out,
    output logic [`N_SECONDARY-1:0] secondary_prot_out,
    output logic ready_busy_pin_out,
    output logic ready_busy_oe_out,
    output logic erase_suspended_out,
    output logic op_done_out,
    output logic cmd_reject_out
);

    localparam int N_FLASH = `N_PRIMARY + `N_SECONDARY;
    localparam int N_SEL = N_FLASH + `N_SRAM;

    // ---------------------------------------------------------------
    // Reset release
    // ---------------------------------------------------------------
    // Assert asynchronously, release on the clock to avoid recovery hazards
    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // ---------------------------------------------------------------
    // Bus pin synchroniser
    // ---------------------------------------------------------------
    // Pins are asynchronous to clk_in; selects lag the pins by three edges
    bus_t bus_meta_reg;
    bus_t bus_sync_reg;

    always_ff @(posedge clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            bus_meta_reg <= '0;
            bus_sync_reg <= '0;
        end else begin
            bus_meta_reg <= bus_in;
            bus_sync_reg <= bus_meta_reg;
        end
    end

    // ---------------------------------------------------------------
    // Decode array
    // ---------------------------------------------------------------
    sel_cfg_t [N_SEL-1:0] all_cfg;
    logic [N_SEL-1:0] sel_comb;
    logic [N_SEL-1:0] sel_reg;

    // Order: primary 0..15, secondary 0..3, SRAM last
    assign all_cfg = {sram_cfg_in, secondary_cfg_in, primary_cfg_in};

    genvar s;
    generate
        for (s = 0; s < N_SEL; s++) begin : g_sel
            sector_term_decoder u_dec (
                .bus_in(bus_sync_reg),
                .cfg_in(all_cfg[s]),
                .sel_out(sel_comb[s])
            );
        end
    endgenerate

    // Registered selects, active high
    always_ff @(posedge clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            sel_reg <= {N_SEL{`SEL_RST}};
        end else begin
            sel_reg <= sel_comb;
        end
    end

    assign primary_sector_sel_out = sel_reg[`N_PRIMARY-1:0];
    assign secondary_sector_sel_out = sel_reg[N_FLASH-1:`N_PRIMARY];
    assign sram_block_sel_out = sel_reg[N_SEL-1];

    // ---------------------------------------------------------------
    // Protection status
    // ---------------------------------------------------------------
    logic [N_FLASH-1:0] prot_reg;

    always_ff @(posedge clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            prot_reg <= {N_FLASH{`PROT_RST}};
        end else begin
            prot_reg <= {secondary_prot_cfg_in, primary_prot_cfg_in};
        end
    end

    assign primary_prot_out = prot_reg[`N_PRIMARY-1:0];
    assign secondary_prot_out = prot_reg[N_FLASH-1:`N_PRIMARY];

    // ---------------------------------------------------------------
    // Program / erase sequencer
    // ---------------------------------------------------------------
    op_state_t state_reg;
    op_state_t state_next;
    logic [`CNT_W-1:0] erase_cnt_reg;
    logic [`CNT_W-1:0] erase_cnt_next;
    logic [`CNT_W-1:0] prog_cnt_reg;
    logic [`CNT_W-1:0] prog_cnt_next;
    logic [N_FLASH-1:0] erase_tgt_reg;
    logic [N_FLASH-1:0] erase_tgt_next;
    logic done_next;
    logic reject_next;
    logic ready_next;

    logic [N_FLASH-1:0] flash_sel;
    logic target_ok;
    logic target_in_erase;

    assign flash_sel = sel_reg[N_FLASH-1:0];
    // A program or erase needs at least one sector selected and no selected sector protected
    assign target_ok = (|flash_sel) && !(|(flash_sel & prot_reg));
    assign target_in_erase = |(flash_sel & erase_tgt_reg);

    // Next-state logic; commands that do not fit the state are refused
    always_comb begin
        state_next = state_reg;
        erase_cnt_next = erase_cnt_reg;
        prog_cnt_next = prog_cnt_reg;
        erase_tgt_next = erase_tgt_reg;
        done_next = 1'b0;
        reject_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (cmd_in.valid) begin
                    if (cmd_in.op == CMD_PROGRAM && target_ok) begin
                        state_next = ST_PROG;
                        prog_cnt_next = PROG_CYCLES - 1'b1;
                    end else if (cmd_in.op == CMD_ERASE && target_ok) begin
                        state_next = ST_ERASE;
                        erase_cnt_next = ERASE_CYCLES - 1'b1;
                        erase_tgt_next = flash_sel;
                    end else begin
                        reject_next = 1'b1;
                    end
                end
            end
            ST_PROG: begin
                reject_next = cmd_in.valid;
                if (prog_cnt_reg == '0) begin
                    state_next = ST_IDLE;
                    done_next = 1'b1;
                end else begin
                    prog_cnt_next = prog_cnt_reg - 1'b1;
                end
            end
            ST_ERASE: begin
                if (cmd_in.valid && cmd_in.op == CMD_SUSPEND) begin
                    state_next = ST_SUSP;
                end else if (erase_cnt_reg == '0) begin
                    reject_next = cmd_in.valid;
                    state_next = ST_IDLE;
                    done_next = 1'b1;
                    erase_tgt_next = '0;
                end else begin
                    reject_next = cmd_in.valid;
                    erase_cnt_next = erase_cnt_reg - 1'b1;
                end
            end
            ST_SUSP: begin
                // Erase count is frozen; other sectors may be read or programmed
                if (cmd_in.valid) begin
                    if (cmd_in.op == CMD_RESUME) begin
                        state_next = ST_ERASE;
                    end else if (cmd_in.op == CMD_PROGRAM && target_ok && !target_in_erase) begin
                        state_next = ST_SUSP_PROG;
                        prog_cnt_next = PROG_CYCLES - 1'b1;
                    end else begin
                        reject_next = 1'b1;
                    end
                end
            end
            ST_SUSP_PROG: begin
                reject_next = cmd_in.valid;
                if (prog_cnt_reg == '0) begin
                    state_next = ST_SUSP;
                    done_next = 1'b1;
                end else begin
                    prog_cnt_next = prog_cnt_reg - 1'b1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // Suspended erase is not an active cycle, so the pin reads ready
        ready_next = (state_next == ST_IDLE) || (state_next == ST_SUSP);
    end

    // State and ready/busy share one process so they move on the same edge
    always_ff @(posedge clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= ST_IDLE;
            ready_busy_pin_out <= `READY_RST;
            erase_suspended_out <= 1'b0;
        end else begin
            state_reg <= state_next;
            ready_busy_pin_out <= ready_next;
            erase_suspended_out <= (state_next == ST_SUSP) || (state_next == ST_SUSP_PROG);
        end
    end

    // Counters and erase target
    always_ff @(posedge clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            erase_cnt_reg <= '0;
            prog_cnt_reg <= '0;
            erase_tgt_reg <= '0;
        end else begin
            erase_cnt_reg <= erase_cnt_next;
            prog_cnt_reg <= prog_cnt_next;
            erase_tgt_reg <= erase_tgt_next;
        end
    end

    // Event pulses and pin drive enable
    always_ff @(posedge clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            op_done_out <= 1'b0;
            cmd_reject_out <= 1'b0;
            ready_busy_oe_out <= 1'b0;
        end else begin
            op_done_out <= done_next;
            cmd_reject_out <= reject_next;
            ready_busy_oe_out <= ready_busy_en_in;
        end
    end

endmodule

`default_nettype wire

// ==== flash_sel_defs.svh ====
// Constants for the flash sector select and program/erase status block
`ifndef FLASH_SEL_DEFS_SVH
`define FLASH_SEL_DEFS_SVH

// ---------------------------------------------------------------
// Array organisation
// ---------------------------------------------------------------
`define N_PRIMARY 16
`define N_SECONDARY 4
`define N_SRAM 1
`define N_TERMS 3
`define ADDR_W 16

// Secondary sector sizes in Kbytes (sector 0..3)
`define SEC0_KBYTES 16
`define SEC1_KBYTES 8
`define SEC2_KBYTES 8
`define SEC3_KBYTES 32
`define PRI_KBYTES 64

// ---------------------------------------------------------------
// Timing counts (device clock cycles) and reset values
// ---------------------------------------------------------------
`define CNT_W 24
`define PROG_CYCLES_DEF 24'h000064
`define ERASE_CYCLES_DEF 24'h004E20
`define SEL_RST 1'b0
`define PROT_RST 1'b0
`define READY_RST 1'b1

`endif

// ==== flash_sel_pkg.sv ====
// Types shared by the flash sector select and status block
package flash_sel_pkg;
`include "flash_sel_defs.svh"

    // One product term: address compare under a care mask, qualified by space
    typedef struct packed {
        logic en;
        logic prog_ok;
        logic data_ok;
        logic [`ADDR_W-1:0] match;
        logic [`ADDR_W-1:0] care;
    } term_t;

    // Up to three product terms OR'ed into one select line
    typedef term_t [`N_TERMS-1:0] sel_cfg_t;

    // Host bus access as seen by the decoder
    typedef struct packed {
        logic valid;
        logic prog_space;
        logic [`ADDR_W-1:0] addr;
    } bus_t;

    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_PROGRAM = 3'h1,
        CMD_ERASE = 3'h2,
        CMD_SUSPEND = 3'h3,
        CMD_RESUME = 3'h4
    } cmd_t;

    typedef struct packed {
        logic valid;
        cmd_t op;
    } cmd_req_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_PROG = 5'h02,
        ST_ERASE = 5'h04,
        ST_SUSP = 5'h08,
        ST_SUSP_PROG = 5'h10
    } op_state_t;

endpackage

// ==== sector_term_decoder.sv ====
// One memory select line built from up to three address product terms
`timescale 1ns/1ps
`default_nettype none
`include "flash_sel_defs.svh"

module sector_term_decoder
    import flash_sel_pkg::*;
(
    input wire bus_t bus_in,
    input wire sel_cfg_t cfg_in,
    output logic sel_out
);

    // ---------------------------------------------------------------
    // Term match
    // ---------------------------------------------------------------
    // Space qualifier lets a sector move between program and data space
    function automatic logic term_hit(input term_t t, input bus_t b);
        logic space_ok;
        space_ok = b.prog_space ? t.prog_ok : t.data_ok;
        term_hit = t.en && space_ok && b.valid && (((b.addr ^ t.match) & t.care) == '0);
    endfunction

    logic [`N_TERMS-1:0] hit;

    genvar i;
    generate
        for (i = 0; i < `N_TERMS; i++) begin : g_term
            assign hit[i] = term_hit(cfg_in[i], bus_in);
        end
    endgenerate

    // Several terms map one sector into several address regions
    assign sel_out = |hit;

endmodule

`default_nettype wire

// ==== host_bus_model.sv ====
// Host bus model driving the block's address pins
`timescale 1ns/1ps
`default_nettype none
`include "flash_sel_defs.svh"
module host_bus_model
    import flash_sel_pkg::*;
(
    input wire logic clk_in,
    input wire logic req_in,
    input wire logic prog_in,
    input wire logic [`ADDR_W-1:0] addr_in,
    output var bus_t bus_out
);
    // A released bus flips every address and space bit on each clock, so a stale hit cannot hide
    always @(posedge clk_in) begin
        bus_out.valid <= req_in;
        bus_out.prog_space <= req_in ? prog_in : ~bus_out.prog_space;
        bus_out.addr <= req_in ? addr_in : ~bus_out.addr;
    end
endmodule
`default_nettype wire

// ==== flash_sel_monitor.sv ====
// Checker for command handling and ready/busy
`timescale 1ns/1ps
`default_nettype none
`include "flash_sel_defs.svh"
module flash_sel_monitor
    import flash_sel_pkg::*;
#(
    parameter logic [`CNT_W-1:0] PROG_CYCLES = `PROG_CYCLES_DEF
)
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire cmd_req_t cmd_in,
    input wire logic [`N_PRIMARY-1:0] primary_sector_sel_out,
    input wire logic [`N_SECONDARY-1:0] secondary_sector_sel_out,
    input wire logic [`N_PRIMARY-1:0] primary_prot_out,
    input wire logic ready_busy_pin_out,
    input wire logic erase_suspended_out,
    input wire logic op_done_out,
    input wire logic cmd_reject_out
);
    // ----------------------------------------
    // Shorthands
    // ----------------------------------------
    localparam int PC = PROG_CYCLES;
    logic idle;
    logic wr;
    assign idle = ready_busy_pin_out && !erase_suspended_out;
    assign wr = cmd_in.valid && (cmd_in.op == CMD_PROGRAM || cmd_in.op == CMD_ERASE);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // Program from idle: busy at once, done with ready exactly PC cycles on
    AST_PROG_LEN: assert property (
        wr && cmd_in.op == CMD_PROGRAM && idle ##1 !cmd_reject_out
        |-> !ready_busy_pin_out ##PC (op_done_out && ready_busy_pin_out)) else $error("program timing");
    AST_ACCEPT_BUSY: assert property (wr && idle |=> cmd_reject_out || !ready_busy_pin_out)
        else $error("accepted command not busy");
    AST_DONE_READY: assert property (op_done_out |-> ready_busy_pin_out)
        else $error("done without ready");
    AST_DONE_AFTER_BUSY: assert property (op_done_out |-> !$past(ready_busy_pin_out))
        else $error("done without busy");
    // A refusal leaves the state alone unless a program or erase ends in that cycle
    AST_REJ_STABLE: assert property (cmd_reject_out && !op_done_out |-> $stable(ready_busy_pin_out)
        && $stable(erase_suspended_out)) else $error("refusal changed state");
    AST_PROT_REJ: assert property (wr && |(primary_sector_sel_out & primary_prot_out) |=> cmd_reject_out)
        else $error("protected sector accepted");
    AST_NOSEL_REJ: assert property (wr && !(|primary_sector_sel_out)
        && !(|secondary_sector_sel_out) |=> cmd_reject_out) else $error("unselected command accepted");
    AST_SUSPEND: assert property (cmd_in.valid && cmd_in.op == CMD_SUSPEND
        |=> cmd_reject_out || op_done_out || (erase_suspended_out && ready_busy_pin_out)) else $error("suspend");
    AST_RESUME: assert property (cmd_in.valid && cmd_in.op == CMD_RESUME && erase_suspended_out
        && ready_busy_pin_out |=> !erase_suspended_out && !ready_busy_pin_out) else $error("resume");
    AST_IDLE_REJ: assert property (cmd_in.valid && idle
        && (cmd_in.op == CMD_SUSPEND || cmd_in.op == CMD_RESUME) |=> cmd_reject_out) else $error("idle suspend");
    COV_DONE: cover property (op_done_out);
    COV_SUSP_PROG: cover property (erase_suspended_out && !ready_busy_pin_out);
    COV_REJ: cover property (cmd_reject_out);
endmodule
bind flash_sector_select_status flash_sel_monitor #(.PROG_CYCLES(PROG_CYCLES)) i_flash_sel_monitor (
    .clk_in(clk_in), .nrst_in(nrst_in), .cmd_in(cmd_in),
    .primary_sector_sel_out(primary_sector_sel_out), .secondary_sector_sel_out(secondary_sector_sel_out),
    .primary_prot_out(primary_prot_out), .ready_busy_pin_out(ready_busy_pin_out),
    .erase_suspended_out(erase_suspended_out), .op_done_out(op_done_out), .cmd_reject_out(cmd_reject_out)
);
`default_nettype wire

// ==== testbench.sv ====
// Testbench for the flash select and ready/busy block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import flash_sel_pkg::*;
;
    logic clk_in = 0, nrst_in = 0, req = 0, prog = 0, en = 1;
    logic [15:0] addr = '0, pprot = '0, psel, pprot_o;
    logic [3:0] sprot = '0, ssel, sprot_o;
    logic [31:0] r;
    sel_cfg_t [15:0] pcfg;
    sel_cfg_t [3:0] scfg;
    sel_cfg_t rcfg;
    cmd_req_t cmd = '0;
    bus_t bus;
    logic rsel, rdy, oe, susp, done, rej;
    int bad_count = 0, checked = 0, seed = 91565;
    logic [1:0] exp_q[$];
    host_bus_model i_host_bus_model (.clk_in(clk_in), .req_in(req), .prog_in(prog), .addr_in(addr), .bus_out(bus));
    // Short counts keep erase runs brief
    flash_sector_select_status #(.PROG_CYCLES(24'h000004), .ERASE_CYCLES(24'h000008)) i_flash_sector_select_status (
        .clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus), .primary_cfg_in(pcfg), .secondary_cfg_in(scfg),
        .sram_cfg_in(rcfg), .primary_prot_cfg_in(pprot), .secondary_prot_cfg_in(sprot), .ready_busy_en_in(en),
        .cmd_in(cmd), .primary_sector_sel_out(psel), .secondary_sector_sel_out(ssel), .sram_block_sel_out(rsel),
        .primary_prot_out(pprot_o), .secondary_prot_out(sprot_o), .ready_busy_pin_out(rdy),
        .ready_busy_oe_out(oe), .erase_suspended_out(susp), .op_done_out(done), .cmd_reject_out(rej));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    initial forever #20 clk_in = ~clk_in;
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            bad_count++;
            $display("Error %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d, errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Waits past the bus model and the synchroniser
    task automatic access(input logic v, input logic p, input logic [15:0] a);
        @(posedge clk_in);
        req <= v;
        prog <= p;
        addr <= a;
        repeat (5) @(posedge clk_in);
        #1;
    endtask
    function automatic logic [20:0] want_sel(input logic p, input logic [15:0] a);
        logic [20:0] w;
        w = '0;
        if (p) w[a[15:12]] = 1'b1;
        if (!p && a[15:12] == 4'h8) w[a[11:8]] = 1'b1;
        if (!p && a[15:12] < 4'h4) w[16 + a[13:12]] = 1'b1;
        if (!p && a[15:12] == 4'hF) w[20] = 1'b1;
        return w;
    endfunction
    // Event codes: 1 done, 2 refused
    task automatic issue(input cmd_t op, input logic [1:0] ev);
        if (ev != 2'h0) exp_q.push_back(ev);
        @(posedge clk_in);
        cmd <= '{1'b1, op};
        @(posedge clk_in);
        cmd <= '0;
        #1;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 200) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (n >= 200) begin
            bad_count++;
            end_of_test();
        end
    endtask
    // Every pulse takes the oldest noted expectation; mid-cycle so the pulse has settled
    always @(negedge clk_in) begin
        if (done === 1'b1 || rej === 1'b1) begin
            check({rej, done}, exp_q.size() ? exp_q.pop_front() : 2'h0);
        end
    end
    initial begin
        for (int i = 0; i < 16; i++) begin
            pcfg[i][0] = '{1'b1, 1'b1, 1'b0, 16'(i << 12), 16'hF000};
            pcfg[i][1] = '{1'b1, 1'b0, 1'b1, 16'(32'h8000 | (i << 8)), 16'hFF00};
            pcfg[i][2] = '{1'b0, 1'b1, 1'b1, 16'h0000, 16'h0000}; // Disabled catch-all
            scfg[i % 4] = '0;
        end
        for (int k = 0; k < 4; k++) scfg[k][0] = '{1'b1, 1'b0, 1'b1, 16'(k << 12), 16'hF000};
        rcfg = '0;
        rcfg[0] = '{1'b1, 1'b0, 1'b1, 16'hF000, 16'hF000};
        repeat (5) @(posedge clk_in);
        #1;
        check({rsel, ssel, psel, rdy, oe}, 23'h000002);
        @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        check({rdy, oe, susp}, 3'b110);
        for (int k = 0; k < 48; k++) begin
            r = $random(seed);
            access(1'b1, r[16], r[15:0]);
            check({rsel, ssel, psel}, want_sel(r[16], r[15:0]));
        end
        // Random protection, with sector 3 locked and 2, 5 and secondary 1 open
        r = $random(seed);
        @(posedge clk_in);
        pprot <= (r[15:0] & 16'hFFDB) | 16'h0008;
        sprot <= r[19:16] & 4'hD;
        access(1'b1, 1'b1, 16'h2000);
        check({sprot_o, pprot_o}, {r[19:16] & 4'hD, (r[15:0] & 16'hFFDB) | 16'h0008});
        issue(CMD_PROGRAM, 2'h0);
        check(rdy, 1'b0);
        issue(CMD_ERASE, 2'h2);
        exp_q.push_back(2'h1);
        wait_ready();
        access(1'b1, 1'b1, 16'h3000);
        issue(CMD_PROGRAM, 2'h2);
        issue(CMD_ERASE, 2'h2);
        access(1'b0, 1'b1, 16'h3000);
        issue(CMD_PROGRAM, 2'h2);
        issue(CMD_SUSPEND, 2'h2);
        issue(CMD_RESUME, 2'h2);
        access(1'b1, 1'b1, 16'h2000);
        issue(CMD_ERASE, 2'h0);
        issue(CMD_SUSPEND, 2'h0);
        check({susp, rdy}, 2'b11);
        issue(CMD_PROGRAM, 2'h2);
        access(1'b1, 1'b0, 16'h8500);
        check(psel, 16'h0020);
        issue(CMD_PROGRAM, 2'h1);
        check({susp, rdy}, 2'b10);
        wait_ready();
        issue(CMD_RESUME, 2'h1);
        check({susp, rdy}, 2'b00);
        wait_ready();
        access(1'b1, 1'b0, 16'h1000);
        issue(CMD_ERASE, 2'h1);
        wait_ready();
        @(posedge clk_in);
        en <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        check(oe, 1'b0);
        check(exp_q.size(), 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
